/* design/redirect_map.vh */
`ifndef REDIRECT_MAP_VH
`define REDIRECT_MAP_VH
// register byte offsets
`define RM_CTRL        8'h00
`define RM_STATUS      8'h04
`define RM_COUNT       8'h08
`define RM_PORT_STACK  8'h10
`define RM_PORT_KEEP   8'h14
`define RM_TAG0        8'h20
`define RM_TAG1        8'h24
`define RM_QCFG_BASE   8'h40
`define RM_QCFG_MASK   8'hE0
// sizes
`define RM_NQ          8
`define RM_QW          3
`define RM_NPORT       16
`define RM_PW          4
// queue config word fields
`define QC_KEEP_LO     0
`define QC_KEEP_HI     1
`define QC_NOREW       2
`define QC_TSEL_LO     3
`define QC_TSEL_HI     4
`define QC_FWD_LO      5
`define QC_FWD_HI      7
`define QC_DPORT_LO    8
`define QC_DPORT_HI    11
`define QC_DUNIT_LO    12
`define QC_DUNIT_HI    16
`define QC_COPY        17
`define QC_WIDTH       18
// tag config word fields
`define TG_VID_LO      0
`define TG_VID_HI      11
`define TG_DEI         12
`define TG_PCPV_LO     13
`define TG_PCPV_HI     15
`define TG_PCPS_LO     16
`define TG_PCPS_HI     17
`define TG_TPID_LO     18
`define TG_TPID_HI     19
`define TG_WIDTH       20
// tag select codes
`define TSEL_NONE      2'h0
`define TSEL_ONE       2'h1
`define TSEL_TWO       2'h2
// reset values
`define RM_CTRL_RST    1'h1
`define RM_TAG_RST     20'h00000
`define RM_PORT_RST    16'h0000
`endif

/* design/redirect_cfg_mem.v */
`timescale 1ns/10ps
`default_nettype none
`include "redirect_map.vh"
module redirect_cfg_mem (
	input  wire                    clk_sys_i,
	input  wire                    ce_i,
	input  wire                    wr_en_i,
	input  wire [`RM_QW-1:0]       wr_addr_i,
	input  wire [`QC_WIDTH-1:0]    wr_data_i,
	input  wire [`RM_QW-1:0]       rd_addr_i,
	output reg  [`QC_WIDTH-1:0]    rd_data_o
);
	reg [`QC_WIDTH-1:0] mem [0:`RM_NQ-1];

	always @(posedge clk_sys_i) begin
		if (ce_i) begin
			if (wr_en_i) begin
				mem[wr_addr_i] <= wr_data_i;
			end
			rd_data_o <= mem[rd_addr_i];
		end
	end
endmodule // redirect_cfg_mem
`default_nettype wire

/* design/cpu_frame_redirect_rewrite.v */
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "redirect_map.vh"
module cpu_frame_redirect_rewrite (
	input  wire                    clk_sys_i,
	input  wire                    rst_i,
	input  wire                    ce_i,
	input  wire [7:0]              avm_address_i,
	input  wire                    avm_read_i,
	input  wire                    avm_write_i,
	input  wire [31:0]             avm_writedata_i,
	output reg  [31:0]             avm_readdata_o,
	output reg                     avm_waitrequest_o,
	input  wire                    desc_valid_i,
	input  wire [`RM_NQ-1:0]       desc_cpu_mask_i,
	input  wire [`RM_PW-1:0]       desc_port_i,
	output reg                     desc_ready_o,
	output reg                     res_valid_o,
	input  wire                    res_ready_i,
	output reg  [`RM_PW-1:0]       res_port_o,
	output reg                     res_redirect_o,
	output reg                     res_to_cpu_o,
	output reg                     res_stack_hdr_o,
	output reg                     res_keep_hdr_o,
	output reg                     res_no_rewrite_o,
	output reg  [1:0]              res_tag_count_o,
	output reg  [`TG_WIDTH-1:0]    res_outer_tag_o,
	output reg  [`TG_WIDTH-1:0]    res_inner_tag_o,
	output reg                     res_stack_tag_ovr_o,
	output reg  [`TG_WIDTH-1:0]    res_stack_tag_o,
	output reg  [2:0]              res_fwd_mode_o,
	output reg  [3:0]              res_dest_port_o,
	output reg  [4:0]              res_dest_unit_o
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_LOOK = 3'b010;
	localparam [2:0] ST_OUT  = 3'b100;

	// highest-numbered set bit of the cpu queue mask
	function [`RM_QW-1:0] top_queue;
		input [`RM_NQ-1:0] m;
		integer i;
		begin
			top_queue = {`RM_QW{1'b0}};
			for (i = 0; i < `RM_NQ; i = i + 1) begin
				if (m[i]) begin
					top_queue = i[`RM_QW-1:0];
				end
			end
		end
	endfunction

	function is_qcfg;
		input [7:0] a;
		begin
			is_qcfg = (a & `RM_QCFG_MASK) == `RM_QCFG_BASE;
		end
	endfunction

	reg  [2:0]              state;
	reg                     ctrl_enable;
	reg  [`RM_NPORT-1:0]    port_stack;
	reg  [`RM_NPORT-1:0]    port_keep;
	reg  [`TG_WIDTH-1:0]    tag0;
	reg  [`TG_WIDTH-1:0]    tag1;
	reg  [31:0]             redirect_count;
	reg  [`RM_NQ-1:0]       lat_mask;
	reg  [`RM_PW-1:0]       lat_port;
	reg                     bus_rd_pend;
	wire [`QC_WIDTH-1:0]    cfg_q;
	wire                    take;
	wire                    bus_req;
	wire                    bus_start;
	wire                    bus_mem_rd;
	wire                    bus_ack;
	wire                    mem_wr;
	wire [`RM_QW-1:0]       mem_rd_addr;
	reg  [31:0]             next_rdata;

	assign take = state[0] & desc_ready_o & desc_valid_i;
	assign bus_req = (avm_read_i | avm_write_i) & avm_waitrequest_o;
	assign bus_start = bus_req & ~bus_rd_pend;
	// acknowledge edge: request still up while waitrequest is low
	assign bus_ack = (avm_read_i | avm_write_i) & ~avm_waitrequest_o;
	assign bus_mem_rd = bus_start & avm_read_i & is_qcfg(avm_address_i) & ~take;
	assign mem_wr = bus_ack & avm_write_i & is_qcfg(avm_address_i);
	assign mem_rd_addr = take ? top_queue(desc_cpu_mask_i) :
		avm_address_i[`RM_QW+1:2];

	// one config word per cpu queue
	redirect_cfg_mem u_cfg (
		.clk_sys_i (clk_sys_i),
		.ce_i      (ce_i),
		.wr_en_i   (mem_wr),
		.wr_addr_i (avm_address_i[`RM_QW+1:2]),
		.wr_data_i (avm_writedata_i[`QC_WIDTH-1:0]),
		.rd_addr_i (mem_rd_addr),
		.rd_data_o (cfg_q)
	);

	always @* begin
		next_rdata = 32'h00000000;
		case (avm_address_i)
			`RM_CTRL: begin
				next_rdata[0] = ctrl_enable;
			end
			`RM_STATUS: begin
				next_rdata[2:0] = state;
			end
			`RM_COUNT: begin
				next_rdata = redirect_count;
			end
			`RM_PORT_STACK: begin
				next_rdata[`RM_NPORT-1:0] = port_stack;
			end
			`RM_PORT_KEEP: begin
				next_rdata[`RM_NPORT-1:0] = port_keep;
			end
			`RM_TAG0: begin
				next_rdata[`TG_WIDTH-1:0] = tag0;
			end
			`RM_TAG1: begin
				next_rdata[`TG_WIDTH-1:0] = tag1;
			end
			default: begin
				next_rdata = 32'h00000000;
			end
		endcase
	end

	// bus slave: writes land on the acknowledge edge
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			avm_waitrequest_o <= 1'b1;
			avm_readdata_o    <= 32'h00000000;
			bus_rd_pend       <= 1'b0;
			ctrl_enable       <= `RM_CTRL_RST;
			port_stack        <= `RM_PORT_RST;
			port_keep         <= `RM_PORT_RST;
			tag0              <= `RM_TAG_RST;
			tag1              <= `RM_TAG_RST;
		end else if (ce_i) begin
			avm_waitrequest_o <= 1'b1;
			if (bus_rd_pend) begin
				bus_rd_pend       <= 1'b0;
				avm_readdata_o    <= {{(32-`QC_WIDTH){1'b0}}, cfg_q};
				avm_waitrequest_o <= 1'b0;
			end else if (bus_ack) begin
				avm_waitrequest_o <= 1'b1;
			end else if (bus_start & avm_read_i) begin
				if (is_qcfg(avm_address_i)) begin
					bus_rd_pend <= bus_mem_rd;
				end else begin
					avm_readdata_o    <= next_rdata;
					avm_waitrequest_o <= 1'b0;
				end
			end else if (bus_start & avm_write_i) begin
				avm_waitrequest_o <= 1'b0;
			end
			if (bus_ack & avm_write_i) begin
				case (avm_address_i)
					`RM_CTRL: begin
						ctrl_enable <= avm_writedata_i[0];
					end
					`RM_PORT_STACK: begin
						port_stack <= avm_writedata_i[`RM_NPORT-1:0];
					end
					`RM_PORT_KEEP: begin
						port_keep <= avm_writedata_i[`RM_NPORT-1:0];
					end
					`RM_TAG0: begin
						tag0 <= avm_writedata_i[`TG_WIDTH-1:0];
					end
					`RM_TAG1: begin
						tag1 <= avm_writedata_i[`TG_WIDTH-1:0];
					end
					default: begin
						ctrl_enable <= ctrl_enable;
					end
				endcase
			end
		end
	end

	// rewrite decision for the looked-up queue
	wire       on_stack  = port_stack[lat_port];
	wire       mask_any  = |lat_mask;
	wire       redirect  = mask_any & cfg_q[`QC_COPY] & ctrl_enable;
	wire [1:0] keep_sel  = cfg_q[`QC_KEEP_HI:`QC_KEEP_LO];
	wire [1:0] tag_sel   = cfg_q[`QC_TSEL_HI:`QC_TSEL_LO];
	wire       keep_eff  = (keep_sel != 2'h0) & ~port_keep[lat_port] & ~on_stack;
	wire       front_rw  = redirect & ~on_stack & ~keep_eff;

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state               <= ST_IDLE;
			desc_ready_o        <= 1'b1;
			lat_mask            <= {`RM_NQ{1'b0}};
			lat_port            <= {`RM_PW{1'b0}};
			redirect_count      <= 32'h00000000;
			res_valid_o         <= 1'b0;
			res_port_o          <= {`RM_PW{1'b0}};
			res_redirect_o      <= 1'b0;
			res_to_cpu_o        <= 1'b0;
			res_stack_hdr_o     <= 1'b0;
			res_keep_hdr_o      <= 1'b0;
			res_no_rewrite_o    <= 1'b0;
			res_tag_count_o     <= 2'h0;
			res_outer_tag_o     <= `RM_TAG_RST;
			res_inner_tag_o     <= `RM_TAG_RST;
			res_stack_tag_ovr_o <= 1'b0;
			res_stack_tag_o     <= `RM_TAG_RST;
			res_fwd_mode_o      <= 3'h0;
			res_dest_port_o     <= 4'h0;
			res_dest_unit_o     <= 5'h00;
		end else if (ce_i) begin
			case (state)
				ST_IDLE: begin
					if (take) begin
						lat_mask     <= desc_cpu_mask_i;
						lat_port     <= desc_port_i;
						desc_ready_o <= 1'b0;
						state        <= ST_LOOK;
					end
				end
				ST_LOOK: begin
					res_valid_o      <= 1'b1;
					res_port_o       <= lat_port;
					res_redirect_o   <= redirect;
					res_to_cpu_o     <= mask_any & ~redirect;
					res_stack_hdr_o  <= on_stack;
					res_keep_hdr_o   <= redirect & keep_eff;
					res_no_rewrite_o <= redirect & ~on_stack &
						(keep_eff | cfg_q[`QC_NOREW]);
					res_tag_count_o  <= 2'h0;
					res_outer_tag_o  <= tag0;
					res_inner_tag_o  <= tag1;
					if (front_rw && tag_sel == `TSEL_ONE) begin
						res_tag_count_o <= 2'h1;
					end
					if (front_rw && tag_sel == `TSEL_TWO) begin
						res_tag_count_o <= 2'h2;
					end
					res_stack_tag_ovr_o <= redirect & on_stack &
						(tag_sel != `TSEL_NONE);
					res_stack_tag_o  <= tag0;
					res_fwd_mode_o   <= cfg_q[`QC_FWD_HI:`QC_FWD_LO];
					res_dest_port_o  <= cfg_q[`QC_DPORT_HI:`QC_DPORT_LO];
					res_dest_unit_o  <= cfg_q[`QC_DUNIT_HI:`QC_DUNIT_LO];
					if (redirect) begin
						redirect_count <= redirect_count + 32'h00000001;
					end
					state <= ST_OUT;
				end
				ST_OUT: begin
					if (res_ready_i) begin
						res_valid_o  <= 1'b0;
						desc_ready_o <= 1'b1;
						state        <= ST_IDLE;
					end
				end
				default: begin
					res_valid_o  <= 1'b0;
					desc_ready_o <= 1'b1;
					state        <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // cpu_frame_redirect_rewrite
`default_nettype wire

/* dv/cpu_frame_redirect_rewrite_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module redirect_checker (
	input wire logic       clk_sys_i,
	input wire logic       rst_i,
	input wire logic       ce_i,
	input wire logic       avm_write_i,
	input wire logic       avm_waitrequest_o,
	input wire logic       desc_valid_i,
	input wire logic [7:0] desc_cpu_mask_i,
	input wire logic       desc_ready_o,
	input wire logic       res_valid_o,
	input wire logic       res_ready_i,
	input wire logic       res_redirect_o,
	input wire logic       res_to_cpu_o,
	input wire logic       res_stack_hdr_o,
	input wire logic       res_keep_hdr_o,
	input wire logic       res_no_rewrite_o,
	input wire logic [1:0] res_tag_count_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (rst_i);
// mask of the descriptor in flight
logic [7:0] m_q;
always @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i)
		m_q <= 8'h00;
	else if (desc_valid_i && desc_ready_o && ce_i)
		m_q <= desc_cpu_mask_i;
end
a_take_answer: assert property (desc_valid_i && desc_ready_o && ce_i |=> !desc_ready_o ##1 res_valid_o)
	else $error("late result");
a_res_hold: assert property (res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_redirect_o)
	&& $stable(res_tag_count_o)) else $error("result changed early");
a_zero_mask: assert property (res_valid_o && m_q == 8'h00 |-> !res_redirect_o && !res_to_cpu_o)
	else $error("zero mask handled");
a_mask_split: assert property (res_valid_o && m_q != 8'h00 |-> res_redirect_o != res_to_cpu_o)
	else $error("bad cpu split");
a_keep_alone: assert property (res_valid_o && res_keep_hdr_o |-> res_redirect_o && res_no_rewrite_o
	&& res_tag_count_o == 2'h0) else $error("keep with edits");
a_keep_front: assert property (res_valid_o && res_stack_hdr_o |-> !res_keep_hdr_o)
	else $error("keep on stack port");
a_tag_front: assert property (res_valid_o && res_tag_count_o != 2'h0 |-> res_redirect_o
	&& !res_stack_hdr_o && res_tag_count_o != 2'h3) else $error("bad tag push");
a_write_ack: assert property ($rose(avm_write_i) |=> !avm_waitrequest_o)
	else $error("write not acked");
a_ack_single: assert property (!avm_waitrequest_o && ce_i |=> avm_waitrequest_o)
	else $error("ack too long");
endmodule // redirect_checker
bind cpu_frame_redirect_rewrite redirect_checker i_chk (.clk_sys_i, .rst_i, .ce_i, .avm_write_i,
	.avm_waitrequest_o, .desc_valid_i, .desc_cpu_mask_i, .desc_ready_o, .res_valid_o,
	.res_ready_i, .res_redirect_o, .res_to_cpu_o, .res_stack_hdr_o, .res_keep_hdr_o,
	.res_no_rewrite_o, .res_tag_count_o);
`default_nettype wire

/* dv/host_sink.sv */
`timescale 1ns/10ps
`default_nettype none
module host_sink (
	input wire logic       clk_sys_i,
	input wire logic       rst_i,
	input wire logic       res_valid_i,
	input wire logic [2:0] stall_i,
	output var logic       res_ready_o
);
// accepts a result after stall_i idle cycles
logic [2:0] cnt;
always @(posedge clk_sys_i or posedge rst_i) begin
	if (rst_i) begin
		cnt <= 3'h0;
		res_ready_o <= 1'b0;
	end else if (res_valid_i && !res_ready_o && cnt >= stall_i) begin
		cnt <= 3'h0;
		res_ready_o <= 1'b1;
	end else if (res_valid_i && !res_ready_o)
		cnt <= cnt + 3'h1;
	else
		res_ready_o <= 1'b0;
end
endmodule // host_sink
`default_nettype wire

/* dv/cpu_frame_redirect_rewrite_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "redirect_map.vh"
module cpu_frame_redirect_rewrite_test;
logic clk_sys_i, rst_i, avm_read_i, avm_write_i, desc_valid_i, ctrl, ce;
logic [7:0] avm_address_i, desc_cpu_mask_i;
logic [31:0] avm_writedata_i, rd;
logic [3:0] desc_port_i;
logic [2:0] stall;
logic [17:0] qw [8];
logic [17:0] ew;
logic [19:0] t0, t1;
logic [15:0] pstk, pkeep;
integer seed, num_errors, n_checks, k, j, i, pass, nred;
wire avm_waitrequest_o, desc_ready_o, res_valid_o, res_ready_i, res_redirect_o, res_to_cpu_o;
wire res_stack_hdr_o, res_keep_hdr_o, res_no_rewrite_o, res_stack_tag_ovr_o;
wire [31:0] avm_readdata_o;
wire [19:0] res_outer_tag_o, res_inner_tag_o, res_stack_tag_o;
wire [1:0] res_tag_count_o;
wire [2:0] res_fwd_mode_o;
wire [3:0] res_port_o, res_dest_port_o;
wire [4:0] res_dest_unit_o;
cpu_frame_redirect_rewrite i_dut (.clk_sys_i, .rst_i, .ce_i(ce), .avm_address_i, .avm_read_i,
	.avm_write_i, .avm_writedata_i, .avm_readdata_o, .avm_waitrequest_o, .desc_valid_i,
	.desc_cpu_mask_i, .desc_port_i, .desc_ready_o, .res_valid_o, .res_ready_i, .res_port_o,
	.res_redirect_o, .res_to_cpu_o, .res_stack_hdr_o, .res_keep_hdr_o, .res_no_rewrite_o,
	.res_tag_count_o, .res_outer_tag_o, .res_inner_tag_o, .res_stack_tag_ovr_o, .res_stack_tag_o,
	.res_fwd_mode_o, .res_dest_port_o, .res_dest_unit_o);
host_sink i_host (.clk_sys_i, .rst_i, .res_valid_i(res_valid_o), .stall_i(stall),
	.res_ready_o(res_ready_i));
initial begin
	clk_sys_i = 1'b0;
	forever #5 clk_sys_i = ~clk_sys_i;
end
task print_verdict;
	$display("checks %0d mismatches %0d", n_checks, num_errors);
	if (num_errors == 0 && n_checks > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
task chk(input [63:0] g, input [63:0] e);
	n_checks = n_checks + 1;
	if (g !== e) begin
		num_errors = num_errors + 1;
		$display("mismatch at %0t got %h exp %h", $time, g, e);
	end
endtask
task bus(input w, input [7:0] a, input [31:0] d);
	@(posedge clk_sys_i);
	avm_address_i <= a;
	avm_writedata_i <= d;
	avm_write_i <= w;
	avm_read_i <= !w;
	k = 0;
	do begin @(posedge clk_sys_i); k = k + 1; end while (avm_waitrequest_o !== 1'b0 && k < 20);
	rd = avm_readdata_o;
	avm_write_i <= 1'b0;
	avm_read_i <= 1'b0;
	if (k == 20) chk(1, 0);
	if (k == 20) print_verdict;
endtask
function [7:0] expf(input [7:0] m, input [3:0] p);
	logic r, st, ke;
	logic [1:0] n;
	ew = qw[0];
	for (int b = 0; b < 8; b++) if (m[b]) ew = qw[b];
	st = pstk[p];
	r = m != 8'h00 && ew[17] && ctrl;
	ke = r && ew[1:0] != 2'h0 && !pkeep[p] && !st;
	n = (r && !st && !ke && (ew[4:3] == 2'h1 || ew[4:3] == 2'h2)) ? ew[4:3] : 2'h0;
	return {r, m != 8'h00 && !r, st, ke, r && !st && (ke || ew[2]), n, r && st && ew[4:3] != 2'h0};
endfunction
task desc(input [7:0] m, input [3:0] p);
	logic [7:0] e;
	e = expf(m, p);
	@(posedge clk_sys_i);
	stall <= 3'($random(seed));
	desc_valid_i <= 1'b1;
	desc_cpu_mask_i <= m;
	desc_port_i <= p;
	k = 0;
	do begin @(posedge clk_sys_i); k = k + 1; end while (desc_ready_o !== 1'b1 && k < 20);
	desc_valid_i <= 1'b0;
	j = 0;
	do begin @(posedge clk_sys_i); j = j + 1; end while (!(res_valid_o === 1'b1
		&& res_ready_i === 1'b1) && j < 60);
	if (k == 20 || j == 60) chk(1, 0);
	if (k == 20 || j == 60) print_verdict;
	chk({res_redirect_o, res_to_cpu_o, res_stack_hdr_o, res_keep_hdr_o, res_no_rewrite_o,
		res_tag_count_o, res_stack_tag_ovr_o}, e);
	chk(res_port_o, p);
	if (e[0]) chk(res_stack_tag_o, t0);
	if (e[2:1] != 2'h0) chk(res_outer_tag_o, t0);
	if (e[2:1] == 2'h2) chk(res_inner_tag_o, t1);
	if (e[7] && e[5]) chk({res_fwd_mode_o, res_dest_port_o, res_dest_unit_o},
		{ew[7:5], ew[11:8], ew[16:12]});
	if (e[7]) nred = nred + 1;
endtask
initial begin
	seed = 32'hcb5b;
	{num_errors, n_checks} = 0;
	nred = 0;
	ce = 1'b1;
	{rst_i, avm_read_i, avm_write_i, desc_valid_i, stall} = 7'h40;
	{avm_address_i, avm_writedata_i, desc_cpu_mask_i, desc_port_i} = 0;
	repeat (20) @(posedge clk_sys_i);
	rst_i <= 1'b0;
	bus(0, `RM_CTRL, 0);
	chk(rd, 1);
	bus(0, `RM_TAG0, 0);
	chk(rd, 0);
	bus(1, 8'hFC, 32'hFFFFFFFF);
	bus(0, 8'hFC, 0);
	chk(rd, 0);
	$display("test reset_values done");
	// clock enable low: an offered descriptor must not be taken
	ce <= 1'b0;
	desc_valid_i <= 1'b1;
	desc_cpu_mask_i <= 8'h01;
	repeat (5) @(posedge clk_sys_i);
	chk({desc_ready_o, res_valid_o}, 2'h2);
	desc_valid_i <= 1'b0;
	ce <= 1'b1;
	$display("test ce_freeze done");
	for (pass = 0; pass < 3; pass++) begin
		ctrl = pass != 1;
		{t0, t1, pstk, pkeep} = {$random(seed), $random(seed), $random(seed)};
		bus(1, `RM_CTRL, {31'h0, ctrl});
		bus(1, `RM_TAG0, {12'h0, t0});
		bus(1, `RM_TAG1, {12'h0, t1});
		bus(1, `RM_PORT_STACK, {16'h0, pstk});
		bus(1, `RM_PORT_KEEP, {16'h0, pkeep});
		for (i = 0; i < 8; i++) begin
			qw[i] = 18'($random(seed));
			bus(1, 8'(`RM_QCFG_BASE + 4 * i), {14'h0, qw[i]});
		end
		for (i = 0; i < 8; i++) begin
			bus(0, 8'(`RM_QCFG_BASE + 4 * i), 0);
			chk(rd, qw[i]);
		end
		bus(0, `RM_TAG1, 0);
		chk(rd, t1);
		for (i = 0; i < 150; i++)
			desc(i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($random(seed)), 4'($random(seed)));
		bus(0, `RM_COUNT, 0);
		chk(rd, nred);
		$display("test traffic pass %0d done", pass);
	end
	print_verdict;
end
endmodule // cpu_frame_redirect_rewrite_test
`default_nettype wire
